// *** src/bsd_defines.svh ***
`ifndef BSD_DEFINES_SVH
`define BSD_DEFINES_SVH
// Instruction opcodes
`define BSD_OP_EXTEST      4'h0
`define BSD_OP_IDCODE      4'h1
`define BSD_OP_SAMPLE      4'h2
`define BSD_OP_DEVRST      4'hC
`define BSD_OP_BYPASS      4'hF
// Value captured into the instruction shifter
`define BSD_IR_CAPTURE     4'h1
// Identification word field positions
`define BSD_ID_VER_MSB     31
`define BSD_ID_VER_LSB     28
`define BSD_ID_PART_MSB    27
`define BSD_ID_PART_LSB    12
`define BSD_ID_MFR_MSB     11
`define BSD_ID_MFR_LSB     1
`define BSD_ID_MARK_BIT    0
// Core control and status register
`define BSD_ADDR_CCSR      8'h00
`define BSD_CCSR_DIS_BIT   7
`define BSD_CCSR_FLAG_BIT  4
`define BSD_DIS_RESET      1'b0
`define BSD_FLAG_RESET     1'b0
`define BSD_DIS_WINDOW     3'h4
// Timing
`define BSD_CLK_NS         10
`define BSD_TOUT0_US       4
`define BSD_TOUT1_US       8
`define BSD_TOUT2_US       16
`define BSD_TOUT3_US       32
`define BSD_US2CYC(us)     (((us) * 1000) / `BSD_CLK_NS)
`endif

// *** src/bsd_pkg.sv ***
package bsd_pkg;
`include "bsd_defines.svh"
   typedef enum logic [15:0] {
      TAP_TLR   = 16'h0001,
      TAP_RTI   = 16'h0002,
      TAP_SELDR = 16'h0004,
      TAP_CAPDR = 16'h0008,
      TAP_SHDR  = 16'h0010,
      TAP_EX1DR = 16'h0020,
      TAP_PADR  = 16'h0040,
      TAP_EX2DR = 16'h0080,
      TAP_UPDR  = 16'h0100,
      TAP_SELIR = 16'h0200,
      TAP_CAPIR = 16'h0400,
      TAP_SHIR  = 16'h0800,
      TAP_EX1IR = 16'h1000,
      TAP_PAIR  = 16'h2000,
      TAP_EX2IR = 16'h4000,
      TAP_UPIR  = 16'h8000
   } bsd_tap_state_e;
   typedef logic [3:0] bsd_instr_t;
endpackage : bsd_pkg

// *** src/bsd_tap_if.sv ***
`timescale 1ns/100ps
interface bsd_tap_if;
   import bsd_pkg::*;
   logic           tck_rise;
   logic           tms;
   logic           hold;
   bsd_tap_state_e state;
   modport ctrl (input tck_rise, input tms, input hold, output state);
   modport user (output tck_rise, output tms, output hold, input state);
endinterface : bsd_tap_if

// *** src/bsd_tap_fsm.sv ***
`timescale 1ns/100ps
module bsd_tap_fsm
   import bsd_pkg::*;
(
   input wire logic clk,         // System clock
   input wire logic rstn,        // Async reset, active low
   bsd_tap_if.ctrl  tap          // Test clock edge, mode select, state
);
   bsd_tap_state_e state;
   bsd_tap_state_e next_state;

   // Sixteen-state controller, one step per test clock rise
   always_comb begin
      next_state = state;
      if (tap.hold) begin
         next_state = TAP_TLR;
      end else if (tap.tck_rise) begin
         case (state)
            TAP_TLR:   next_state = tap.tms ? TAP_TLR   : TAP_RTI;
            TAP_RTI:   next_state = tap.tms ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: next_state = tap.tms ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: next_state = tap.tms ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR:  next_state = tap.tms ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: next_state = tap.tms ? TAP_UPDR  : TAP_PADR;
            TAP_PADR:  next_state = tap.tms ? TAP_EX2DR : TAP_PADR;
            TAP_EX2DR: next_state = tap.tms ? TAP_UPDR  : TAP_SHDR;
            TAP_UPDR:  next_state = tap.tms ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: next_state = tap.tms ? TAP_TLR   : TAP_CAPIR;
            TAP_CAPIR: next_state = tap.tms ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR:  next_state = tap.tms ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: next_state = tap.tms ? TAP_UPIR  : TAP_PAIR;
            TAP_PAIR:  next_state = tap.tms ? TAP_EX2IR : TAP_PAIR;
            TAP_EX2IR: next_state = tap.tms ? TAP_UPIR  : TAP_SHIR;
            TAP_UPIR:  next_state = tap.tms ? TAP_SELDR : TAP_RTI;
            default:   next_state = TAP_TLR;
         endcase
      end
   end

   // State register, power-on reset or hold returns it to reset state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= TAP_TLR;
      end else begin
         state <= next_state;
      end
   end

   assign tap.state = state;

   // Controller checks
   a_tlr_stays: assert property (@(posedge clk) disable iff (!rstn)
      tap.tck_rise && tap.tms && !tap.hold && state == TAP_TLR |=> state == TAP_TLR)
      else $error("controller left test-logic-reset with mode select high");
   a_cap_to_shift: assert property (@(posedge clk) disable iff (!rstn)
      tap.tck_rise && !tap.tms && !tap.hold && state == TAP_CAPDR |=> state == TAP_SHDR)
      else $error("capture-dr did not advance to shift-dr");
endmodule : bsd_tap_fsm

// *** src/bsd_top.sv ***
// Summary of operation
// - Chain drives and samples every pin
// - Identification instruction selected after power-up
// - Reset puts all pin outputs high-impedance, except under EXTEST
// - Reset from pin or reset instruction
// - EXTEST drives latches onto pins immediately
// - SAMPLE captures pins without disturbing core
// - Port works only if fuse set, disable clear
// - Scan runs on the system clock, stepped by test clock edges
// - Bypass is one stage, captures zero
// - Identification bits 31:28 hold version
// - Version is revision modulo sixteen
// - Identification bits 27:12 hold part number
// - Bits 11:1 manufacturer, bit 0 one
// - Reset register one equals reset pin low
// - Reset held while reset instruction is selected and reset register is one
// - Fuse-selected time-out after reset register clears
// - Reset register acts unlatched, immediately
// - Four-bit instructions: 0,1,2,C,F
// - All shifters move least significant first
// - Reset instruction never resets the controller
// - Reset-register reset sets source flag
`timescale 1ns/100ps
module bsd_top
   import bsd_pkg::*;
#(
   parameter int          N_PINS      = 8,         // Boundary pins incl. analog interface points
   parameter int          SILICON_REV = 0,         // Revision index, 0 = first
   parameter logic [15:0] PART_NUMBER = 16'h5A3C,  // Arbitrary value
   parameter logic [10:0] MFR_CODE    = 11'h2B5    // Arbitrary value
)(
   input  wire logic              clk,          // System clock, 100 MHz
   input  wire logic              rstn,         // Power-on reset, active low
   input  wire logic              tck,          // Test clock pin
   input  wire logic              tms,          // Test mode select pin
   input  wire logic              tdi,          // Test data in pin
   output logic                   tdo,          // Test data out
   output logic                   tdo_oe,       // Test data out enable
   input  wire logic              ext_rst_n,    // External reset pin, active low
   input  wire logic              test_port_enable_fuse, // Port enable fuse
   input  wire logic [1:0]        clk_opt_fuse, // Clock option fuses, pick time-out
   output logic                   core_rst_n,   // Reset to the core, active low
   input  wire logic [N_PINS-1:0] core_out,     // Core output data
   input  wire logic [N_PINS-1:0] core_oe,      // Core output enables
   output logic [N_PINS-1:0]      core_in,      // Pin levels to the core
   input  wire logic [N_PINS-1:0] pad_in,       // Pin input levels
   output logic [N_PINS-1:0]      pad_out,      // Pin output data
   output logic [N_PINS-1:0]      pad_oe,       // Pin output enables
   input  wire logic [7:0]        reg_addr,     // Register address
   input  wire logic [7:0]        reg_wdata,    // Register write data
   input  wire logic              reg_wr,       // Write strobe
   input  wire logic              reg_rd,       // Read strobe
   output logic [7:0]             reg_rdata     // Read data, cycle after strobe
);
   localparam int         CHAIN = 3 * N_PINS;
   localparam logic [3:0] VERSION = 4'(SILICON_REV % 16);
   localparam logic [31:0] ID_WORD = {VERSION, PART_NUMBER, MFR_CODE, 1'b1};
   localparam logic [11:0] TOUT0 = 12'(`BSD_US2CYC(`BSD_TOUT0_US));
   localparam logic [11:0] TOUT1 = 12'(`BSD_US2CYC(`BSD_TOUT1_US));
   localparam logic [11:0] TOUT2 = 12'(`BSD_US2CYC(`BSD_TOUT2_US));
   localparam logic [11:0] TOUT3 = 12'(`BSD_US2CYC(`BSD_TOUT3_US));

   logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
   logic xr_s1, xr_s2, fz_s1, fz_s2;
   logic [N_PINS-1:0] pad_s1, pad_s2;
   logic tck_rise, tck_fall, tap_en;

   // Two-stage synchronisers for every pin input except the clock option fuses
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {tck_s1, tck_s2, tck_s3} <= 3'h0;
         {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hF;
         {xr_s1, xr_s2, fz_s1, fz_s2} <= 4'hC;
         pad_s1 <= '0;
         pad_s2 <= '0;
      end else begin
         tck_s1 <= tck;
         tck_s2 <= tck_s1;
         tck_s3 <= tck_s2;
         tms_s1 <= tms;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi;
         tdi_s2 <= tdi_s1;
         xr_s1  <= ext_rst_n;
         xr_s2  <= xr_s1;
         fz_s1  <= test_port_enable_fuse;
         fz_s2  <= fz_s1;
         pad_s1 <= pad_in;
         pad_s2 <= pad_s1;
      end
   end

   // Test clock edges found by the system clock
   assign tck_rise = tck_s2 && !tck_s3;
   assign tck_fall = !tck_s2 && tck_s3;

   bsd_tap_if tap ();
   assign tap.tck_rise = tck_rise;
   assign tap.tms      = tms_s2;
   assign tap.hold     = !tap_en;

   // Controller, reset only by power-on reset, disable or fuse clear
   bsd_tap_fsm u_fsm (
      .clk  (clk),
      .rstn (rstn),
      .tap  (tap)
   );

   bsd_tap_state_e st;
   assign st = tap.state;

   logic [3:0]       ir_shift, next_ir_shift;
   bsd_instr_t       ir, next_ir;
   logic             bypass, next_bypass;
   logic [31:0]      id_shift, next_id_shift;
   logic             rst_cell, next_rst_cell;
   logic [CHAIN-1:0] chain, next_chain, cap_vec;
   logic [N_PINS-1:0] out_lat, next_out_lat, oe_lat, next_oe_lat, lat_d, lat_e;
   logic             next_tdo, next_tdo_oe;
   logic             sel_extest, sel_bsc;

   assign sel_extest = (ir == `BSD_OP_EXTEST);
   assign sel_bsc    = sel_extest || (ir == `BSD_OP_SAMPLE);

   // Per pin cells: input level, output data, output control
   genvar gi;
   generate
      for (gi = 0; gi < N_PINS; gi++) begin : g_cell
         assign cap_vec[3*gi+2:3*gi] = {core_oe[gi], core_out[gi], pad_s2[gi]};
         assign lat_d[gi] = chain[3*gi+1];
         assign lat_e[gi] = chain[3*gi+2];
      end
   endgenerate

   // Instruction and data shifters, tdo on the falling edge
   always_comb begin
      next_ir_shift = ir_shift;
      next_ir       = ir;
      next_bypass   = bypass;
      next_id_shift = id_shift;
      next_rst_cell = rst_cell;
      next_chain    = chain;
      next_out_lat  = out_lat;
      next_oe_lat   = oe_lat;
      next_tdo      = tdo;
      next_tdo_oe   = tdo_oe;
      if (!tap_en) begin
         next_ir     = `BSD_OP_IDCODE;
         next_tdo_oe = 1'b0;
      end else if (tck_rise) begin
         if (st == TAP_TLR)
            next_ir = `BSD_OP_IDCODE;
         if (st == TAP_CAPIR)
            next_ir_shift = `BSD_IR_CAPTURE;
         if (st == TAP_SHIR)
            next_ir_shift = {tdi_s2, ir_shift[3:1]};
         if (st == TAP_CAPDR) begin
            if (ir == `BSD_OP_IDCODE)
               next_id_shift = ID_WORD;
            else if (sel_bsc)
               next_chain = cap_vec;
            else if (ir != `BSD_OP_DEVRST)
               next_bypass = 1'b0;
         end
         if (st == TAP_SHDR) begin
            if (ir == `BSD_OP_IDCODE)
               next_id_shift = {tdi_s2, id_shift[31:1]};
            else if (sel_bsc)
               next_chain = {tdi_s2, chain[CHAIN-1:1]};
            else if (ir == `BSD_OP_DEVRST)
               next_rst_cell = tdi_s2;
            else
               next_bypass = tdi_s2;
         end
      end else if (tck_fall) begin
         if (st == TAP_UPIR)
            next_ir = ir_shift;
         if (st == TAP_UPDR && sel_bsc) begin
            next_out_lat = lat_d;
            next_oe_lat  = lat_e;
         end
         next_tdo_oe = (st == TAP_SHIR) || (st == TAP_SHDR);
         if (st == TAP_SHIR)
            next_tdo = ir_shift[0];
         else if (ir == `BSD_OP_IDCODE)
            next_tdo = id_shift[0];
         else if (sel_bsc)
            next_tdo = chain[0];
         else if (ir == `BSD_OP_DEVRST)
            next_tdo = rst_cell;
         else
            next_tdo = bypass;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ir_shift <= `BSD_IR_CAPTURE;
         ir       <= `BSD_OP_IDCODE;
         bypass   <= 1'b0;
         id_shift <= '0;
         rst_cell <= 1'b0;
         chain    <= '0;
         out_lat  <= '0;
         oe_lat   <= '0;
         tdo      <= 1'b0;
         tdo_oe   <= 1'b0;
      end else begin
         ir_shift <= next_ir_shift;
         ir       <= next_ir;
         bypass   <= next_bypass;
         id_shift <= next_id_shift;
         rst_cell <= next_rst_cell;
         chain    <= next_chain;
         out_lat  <= next_out_lat;
         oe_lat   <= next_oe_lat;
         tdo      <= next_tdo;
         tdo_oe   <= next_tdo_oe;
      end
   end

   // Reset request, time-out and source flag
   logic        rst_by_reg, rst_req, core_rst;
   logic [11:0] tout, cnt, next_cnt;
   logic        dis, next_dis, flag, next_flag, arm_val, next_arm_val;
   logic [2:0]  arm_cnt, next_arm_cnt;
   logic [7:0]  next_rdata;
   logic        ccsr_wr;

   assign rst_by_reg = (ir == `BSD_OP_DEVRST) && rst_cell;
   assign rst_req    = !xr_s2 || rst_by_reg;
   assign core_rst   = rst_req || (cnt != 12'h000);
   assign tap_en     = fz_s2 && !dis;
   assign ccsr_wr    = reg_wr && (reg_addr == `BSD_ADDR_CCSR);

   always_comb begin
      case (clk_opt_fuse)
         2'h0:    tout = TOUT0;
         2'h1:    tout = TOUT1;
         2'h2:    tout = TOUT2;
         default: tout = TOUT3;
      endcase
   end

   always_comb begin
      next_cnt     = cnt;
      next_dis     = dis;
      next_flag    = flag;
      next_arm_val = arm_val;
      next_arm_cnt = arm_cnt;
      next_rdata   = 8'h00;
      if (rst_req)
         next_cnt = tout;
      else if (cnt != 12'h000)
         next_cnt = cnt - 12'h001;
      if (arm_cnt != 3'h0)
         next_arm_cnt = arm_cnt - 3'h1;
      if (ccsr_wr) begin
         if (arm_cnt != 3'h0 && reg_wdata[`BSD_CCSR_DIS_BIT] == arm_val) begin
            next_dis     = arm_val;
            next_arm_cnt = 3'h0;
         end else begin
            next_arm_val = reg_wdata[`BSD_CCSR_DIS_BIT];
            next_arm_cnt = `BSD_DIS_WINDOW;
         end
         if (!reg_wdata[`BSD_CCSR_FLAG_BIT])
            next_flag = 1'b0;
      end
      if (rst_by_reg)
         next_flag = 1'b1;
      if (reg_rd && reg_addr == `BSD_ADDR_CCSR) begin
         next_rdata[`BSD_CCSR_DIS_BIT]  = dis;
         next_rdata[`BSD_CCSR_FLAG_BIT] = flag;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt       <= 12'h000;
         dis       <= `BSD_DIS_RESET;
         flag      <= `BSD_FLAG_RESET;
         arm_val   <= 1'b0;
         arm_cnt   <= 3'h0;
         reg_rdata <= 8'h00;
      end else begin
         cnt       <= next_cnt;
         dis       <= next_dis;
         flag      <= next_flag;
         arm_val   <= next_arm_val;
         arm_cnt   <= next_arm_cnt;
         reg_rdata <= next_rdata;
      end
   end

   // Pin multiplexing: test latches under EXTEST, else core
   assign core_rst_n = !core_rst;
   assign core_in    = pad_s2;
   assign pad_out    = sel_extest ? out_lat : core_out;
   assign pad_oe     = sel_extest ? oe_lat : (core_rst ? '0 : core_oe);

   // Checks
   a_rst_hiz: assert property (@(posedge clk) disable iff (!rstn)
      core_rst && !sel_extest |-> pad_oe == '0)
      else $error("pins driven during reset");
   a_rst_cause: assert property (@(posedge clk) disable iff (!rstn)
      (!xr_s2 || (ir == `BSD_OP_DEVRST && rst_cell)) |-> !core_rst_n)
      else $error("reset request did not reset core");
   a_extest_drive: assert property (@(posedge clk) disable iff (!rstn)
      ir == `BSD_OP_EXTEST |-> pad_out == out_lat && pad_oe == oe_lat)
      else $error("extest not driving latches");
   a_sample_quiet: assert property (@(posedge clk) disable iff (!rstn)
      ir == `BSD_OP_SAMPLE && !core_rst |-> pad_out == core_out && pad_oe == core_oe)
      else $error("sample disturbed pins");
   a_port_off: assert property (@(posedge clk) disable iff (!rstn)
      !tap_en ##1 !tap_en |-> !tdo_oe && st == TAP_TLR)
      else $error("disabled port active");
   a_bypass_zero: assert property (@(posedge clk) disable iff (!rstn)
      tck_rise && tap_en && st == TAP_CAPDR && ir == `BSD_OP_BYPASS |=> !bypass)
      else $error("bypass did not capture zero");
   a_id_capture: assert property (@(posedge clk) disable iff (!rstn)
      tck_rise && tap_en && st == TAP_CAPDR && ir == `BSD_OP_IDCODE |=> id_shift == ID_WORD && id_shift[0])
      else $error("identification word not captured");
   a_ir_lsb: assert property (@(posedge clk) disable iff (!rstn)
      tck_rise && tap_en && st == TAP_SHIR |=> ir_shift[3] == $past(tdi_s2) && ir_shift[2:0] == $past(ir_shift[3:1]))
      else $error("instruction shift order wrong");
   a_rst_timeout: assert property (@(posedge clk) disable iff (!rstn)
      $fell(rst_req) |-> (cnt == tout) ##0 (!core_rst_n) [*8])
      else $error("reset released before time-out");
   a_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      rst_by_reg |=> flag)
      else $error("reset source flag not set");
   a_tlr_idcode: assert property (@(posedge clk) disable iff (!rstn)
      tck_rise && tap_en && st == TAP_TLR |=> ir == `BSD_OP_IDCODE)
      else $error("idcode not selected in reset state");

   c_extest: cover property (@(posedge clk) disable iff (!rstn) ir == `BSD_OP_EXTEST && tck_fall && st == TAP_UPDR);
   c_devrst: cover property (@(posedge clk) disable iff (!rstn) $fell(rst_by_reg) ##1 core_rst);
   c_idshift: cover property (@(posedge clk) disable iff (!rstn) st == TAP_SHDR && ir == `BSD_OP_IDCODE && tdo_oe);
   c_dis_set: cover property (@(posedge clk) disable iff (!rstn) $rose(dis));
endmodule : bsd_top

// *** test/bsd_scan_host.sv ***
`timescale 1ns/100ps
module bsd_scan_host (
   output logic      tck,    // Test clock, still between frames
   output logic      tms,    // Test mode select
   output logic      tdi,    // Test data in
   input  wire logic tdo,    // Test data out
   input  wire logic tdo_oe  // Test data out enable
);
   wire tdo_line = tdo_oe ? tdo : 1'b1;  // Pull-up once released
   // Idle levels
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One test clock period, sample at the rise
   task automatic pulse(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #62.5 tck = 1'b1;
      q = tdo_line;
      #62.5 tck = 1'b0;
   endtask : pulse
   // Five ones reach reset from any state, then idle
   task automatic reset_tap;
      logic q;
      repeat (5) pulse(1'b1, 1'b1, q);
      pulse(1'b0, 1'b1, q);
   endtask : reset_tap
   // Scan from idle back to idle; n-bit IR when ir is set
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      pulse(1'b1, 1'b1, q);
      if (ir) pulse(1'b1, 1'b1, q);
      pulse(1'b0, 1'b1, q);
      pulse(1'b0, 1'b1, q);
      // Least significant bit first both ways
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], q);
         dout[i] = q;
      end
      pulse(1'b1, 1'b1, q);
      pulse(1'b0, 1'b1, q);
   endtask : scan
endmodule : bsd_scan_host

// *** test/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import bsd_pkg::*;
   localparam int          REV  = 17;        // Index 17, eighteenth revision, wraps to 1
   localparam logic [15:0] PART = 16'h5A3C;  // Arbitrary value
   localparam logic [10:0] MFR  = 11'h2B5;   // Arbitrary value
   localparam logic [31:0] ID   = {4'h1, PART, MFR, 1'b1};
   logic       clk, rstn, tck, tms, tdi, tdo, tdo_oe, ext_rst_n, test_port_enable_fuse;
   logic       core_rst_n, reg_wr, reg_rd;
   logic [1:0] clk_opt_fuse;
   logic [7:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe, reg_addr, reg_wdata, reg_rdata, d;
   logic [31:0] got;
   logic [3:0] ops [5];                      // Bypass and undefined opcodes
   int         miscompares, n_checks, cycles, k;

   bsd_top #(.SILICON_REV(REV), .PART_NUMBER(PART), .MFR_CODE(MFR)) dut (
      .clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .ext_rst_n(ext_rst_n), .test_port_enable_fuse(test_port_enable_fuse), .clk_opt_fuse(clk_opt_fuse),
      .core_rst_n(core_rst_n), .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   bsd_scan_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   // System clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // Back-to-back write strobes, n of them
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input int n);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      repeat (n) @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // Chain layout: pad level, out data, out enable per pin
   function automatic logic [31:0] pack(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      pack = '0;
      for (int i = 0; i < 8; i++) pack[3*i +: 3] = {c[i], b[i], a[i]};
   endfunction : pack
   task automatic t_ident;
      ops = '{4'hF, 4'h3, 4'h7, 4'hD, 4'hE};
      host.scan(1'b0, 32, 32'h0, got);
      check(got, ID, "first scan id");
      host.scan(1'b1, 4, 32'hF, got);
      check(got, 32'h1, "ir capture");
      // Bypass and undefined codes: one stage that captured zero
      foreach (ops[i]) begin
         host.scan(1'b1, 4, {28'h0, ops[i]}, got);
         host.scan(1'b0, 8, 32'hB4, got);
         check(got, 32'h68, "bypass shift");
      end
      host.scan(1'b1, 4, 32'h1, got);
      host.scan(1'b0, 32, 32'h0, got);
      check(got, ID, "id reload");
      $display("Done: ident");
   endtask : t_ident
   task automatic t_chain;
      @(posedge clk);
      pad_in <= 8'hA5;
      core_out <= 8'h3C;
      core_oe <= 8'h0F;
      repeat (4) @(posedge clk);
      // Safe values preloaded before the first EXTEST
      host.scan(1'b1, 4, 32'h2, got);
      host.scan(1'b0, 24, pack(8'h00, 8'h96, 8'hF0), got);
      check(got, pack(8'hA5, 8'h3C, 8'h0F), "sample capture");
      check(pad_out, core_out, "sample out");
      check(pad_oe, core_oe, "sample oe");
      check(core_in, pad_in, "sample in");
      host.scan(1'b1, 4, 32'h0, got);
      check(pad_out, 8'h96, "extest out");
      check(pad_oe, 8'hF0, "extest oe");
      host.scan(1'b1, 4, 32'hF, got);
      check(pad_out, 8'h3C, "pins back");
      $display("Done: chain");
   endtask : t_chain
   task automatic t_reset;
      host.scan(1'b1, 4, 32'hC, got);
      host.scan(1'b0, 1, 32'h1, got);
      check(core_rst_n, 1'b0, "reset on");
      check(pad_oe, 8'h00, "pins hi-z");
      repeat (1000) @(posedge clk);
      check(core_rst_n, 1'b0, "reset held");
      rd(8'h00, d);
      check(d & 8'h10, 8'h10, "flag set");
      host.scan(1'b0, 1, 32'h0, got);
      k = 0;
      while (core_rst_n !== 1'b1 && k < 600) begin
         @(posedge clk);
         k++;
      end
      check(k >= 300 && k <= 400, 1'b1, "time-out");
      // Controller kept its state: scan from idle works
      host.scan(1'b1, 4, 32'h1, got);
      check(got, 32'h1, "tap intact");
      wr(8'h00, 8'h00, 1);
      rd(8'h00, d);
      check(d, 8'h00, "flag clear");
      rd(8'h05, d);
      check(d, 8'h00, "unmapped");
      @(posedge clk);
      clk_opt_fuse <= 2'h1;
      ext_rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      check(core_rst_n, 1'b0, "pin reset");
      check(pad_oe, 8'h00, "pin hi-z");
      ext_rst_n <= 1'b1;
      k = 0;
      while (core_rst_n !== 1'b1 && k < 1200) begin
         @(posedge clk);
         k++;
      end
      check(core_rst_n, 1'b1, "pin release");
      check(k >= 795 && k <= 810, 1'b1, "fuse time-out");
      clk_opt_fuse <= 2'h0;
      $display("Done: reset");
   endtask : t_reset
   task automatic t_enable;
      wr(8'h00, 8'h80, 1);
      repeat (6) @(posedge clk);
      wr(8'h00, 8'h80, 1);
      rd(8'h00, d);
      check(d, 8'h00, "single write");
      wr(8'h00, 8'h80, 2);
      rd(8'h00, d);
      check(d, 8'h80, "disable bit");
      host.scan(1'b0, 32, 32'h0, got);
      check(got, 32'hFFFFFFFF, "disabled");
      wr(8'h00, 8'h00, 2);
      host.reset_tap();
      host.scan(1'b0, 32, 32'h0, got);
      check(got, ID, "enabled");
      @(posedge clk);
      test_port_enable_fuse <= 1'b0;
      host.scan(1'b0, 32, 32'h0, got);
      check(got, 32'hFFFFFFFF, "fuse off");
      $display("Done: enable");
   endtask : t_enable
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // Main sequence
   initial begin
      {rstn, reg_wr, reg_rd, core_out, core_oe, pad_in, reg_addr, reg_wdata, clk_opt_fuse} = '0;
      {ext_rst_n, test_port_enable_fuse} = 2'b11;
      {miscompares, n_checks, cycles} = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      host.reset_tap();
      t_ident();
      t_chain();
      t_reset();
      t_enable();
      summarize();
   end
endmodule : tb_top
